// file: src/eepc_core.sv
// Serial EEPROM core: power-on state, ECC groups, write cycle, AXI view
`timescale 1ns/1ps
`default_nettype none
`include "eepc_defs.svh"
// Function
// [RQ1] Ignore every frame until power-on reset releases
// [RQ2] Reset clears the write enable latch
// [RQ3] Reset clears the write in progress flag
// [RQ4] Reset keeps stored guard bits unchanged
// [RQ5] After reset: standby, deselected, not held
// [RQ6] Drive serial output only while selected
// [RQ7] Correct one bad bit per group on read
// [RQ8] Groups are four bytes aligned to four
// [RQ9] Byte write rewrites the whole group
// [RQ10] Correction never alters bus protocol or timing
// [RQ11] Delivered array reads all ones
// [RQ12] Delivered guard bits are zero
// [RQ13] Delivered ident page starts with code
// [RQ14] Write-type instructions run an internal cycle
// [RQ15] Cycle starts at select release, lasts tW
// [RQ16] Drop write instructions while cycle runs
// [RQ17] Correction raises no flag, adds no delay
module eepc_core #(
    parameter int GROUPS = `EEPC_GROUPS,
    parameter int TW_CYC = `EEPC_TW_CYC,
    // Identification value is arbitrary
    parameter logic [23:0] ID_CODE = `EEPC_ID_CODE
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe
);
    localparam int CW = `EEPC_CW_W;
    localparam int DEPTH = GROUPS + `EEPC_ID_GROUPS;
    localparam int AW = $clog2(DEPTH);
    localparam int AB = $clog2(GROUPS) + 2;
    localparam int TB = $clog2(TW_CYC + 1);

    if (GROUPS < `EEPC_ID_GROUPS || (GROUPS & (GROUPS - 1)) != 0 ||
        AB > 24) begin : g_bad_groups
        $error("GROUPS must be a power of two from 64 to 4M");
    end
    if (TW_CYC < 8) begin : g_bad_tw
        $error("TW_CYC must be at least 8");
    end

    // Hamming code: check bits sit at power-of-two positions 1..32
    function automatic eepc_pkg::eepc_cw_t ecc_enc(input logic [31:0] d);
        eepc_pkg::eepc_cw_t c;
        int k;
        c = '0;
        k = 0;
        for (int p = 1; p <= CW; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p-1] = d[k];
                k++;
            end
        end
        for (int i = 0; i < `EEPC_CHK_W; i++) begin
            for (int p = 1; p <= CW; p++) begin
                if ((p & (1 << i)) != 0 && p != (1 << i)) begin
                    c[(1<<i)-1] = c[(1<<i)-1] ^ c[p-1];
                end
            end
        end
        return c;
    endfunction

    function automatic logic [5:0] ecc_syn(input eepc_pkg::eepc_cw_t c);
        logic [5:0] s;
        s = '0;
        for (int p = 1; p <= CW; p++) begin
            if (c[p-1]) begin
                s = s ^ 6'(p);
            end
        end
        return s;
    endfunction

    function automatic logic [31:0] ecc_dec(input eepc_pkg::eepc_cw_t cw);
        eepc_pkg::eepc_cw_t c;
        logic [5:0] s;
        logic [31:0] r;
        int k;
        c = cw;
        s = ecc_syn(cw);
        r = '0;
        k = 0;
        // Silent repair: no flag is kept of it [RQ7] [RQ17]
        if (s != 6'h00 && int'(s) <= CW) begin
            c[int'(s)-1] = ~c[int'(s)-1];
        end
        for (int p = 1; p <= CW; p++) begin
            if ((p & (p - 1)) != 0) begin
                r[k] = c[p-1];
                k++;
            end
        end
        return r;
    endfunction

    // Word index of a byte's group; byte address bits 1:0 dropped
    function automatic logic [AW-1:0] grp_of(input logic id,
                                             input logic [AB-1:0] a);
        if (id) begin
            return AW'(GROUPS) + AW'(a[7:2]); // [RQ8]
        end
        return AW'(a[AB-1:2]); // [RQ8]
    endfunction

    localparam eepc_pkg::eepc_cw_t FILL_CW = ecc_enc({4{`EEPC_ERASED}});
    localparam eepc_pkg::eepc_cw_t ID_CW = ecc_enc({`EEPC_ERASED,
        ID_CODE[7:0], ID_CODE[15:8], ID_CODE[23:16]});

    // ---- Link side, on the serial clock
    logic [1:0] por_l_q;
    logic [2:0] bit_q, byt_q, lastb_q;
    logic [7:0] sh_q, cmd_q, data_q;
    logic [7:0] sr_l1_q, sr_l2_q, sr_byte;
    logic [23:0] addr_q;
    logic [AB-1:0] p_q, p_d, wad_q;
    logic endb_q, fpor_q, so_q, oe_q;
    // The link has no reset, so frame parity must start known
    logic frm_q = 1'b0;
    logic [7:0] byte_in, out_byte, rd_byte;
    logic [31:0] rd_word;
    logic is_rd_l, rd_phase;
    logic [CW-1:0] b_rdata;

    assign byte_in = {sh_q[6:0], spi_mosi};
    assign is_rd_l = cmd_q == `EEPC_OP_READ || cmd_q == `EEPC_OP_RDID;

    always_ff @(posedge spi_sck) begin
        por_l_q <= {por_l_q[0], aresetn};
        sr_l1_q <= sr_byte;
        sr_l2_q <= sr_l1_q;
    end

    // Bit and byte counters restart with every select
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_q <= 3'h0;
            byt_q <= 3'h0;
        end else begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7 && byt_q != `EEPC_DATA_BYTE) begin
                byt_q <= byt_q + 3'h1;
            end
        end
    end

    // Frame record; left standing after select rises for the core side
    always_ff @(posedge spi_sck) begin
        sh_q <= byte_in;
        p_q <= p_d;
        endb_q <= bit_q == 3'h7;
        lastb_q <= byt_q;
        if (bit_q == 3'h0 && byt_q == 3'h0) begin
            frm_q <= ~frm_q;
        end
        // Third edge: the sync then holds this frame's first edge, not
        // a stale value left from before the serial clock stopped
        if (bit_q == 3'h2 && byt_q == 3'h0) begin
            fpor_q <= por_l_q[1]; // [RQ1]
        end
        if (bit_q == 3'h7) begin
            if (byt_q == 3'h0) begin
                cmd_q <= byte_in;
            end else begin
                data_q <= byte_in;
            end
            if (byt_q != 3'h0 && byt_q != `EEPC_DATA_BYTE) begin
                addr_q <= {addr_q[15:0], byte_in};
            end
            if (byt_q == `EEPC_DATA_BYTE) begin
                wad_q <= p_q;
            end
        end
    end

    // Next pointer feeds the array at once, so data are ready in time
    always_comb begin
        p_d = p_q;
        if (bit_q == 3'h7 && byt_q == 3'h3) begin
            p_d = AB'({addr_q[15:0], byte_in});
        end else if (bit_q == 3'h7 && byt_q == `EEPC_DATA_BYTE) begin
            if (is_rd_l) begin
                p_d = p_q + AB'(1);
            end else begin
                p_d[7:0] = p_q[7:0] + 8'h01;
            end
        end
    end

    assign rd_word = ecc_dec(b_rdata); // [RQ7]
    assign rd_byte = rd_word[8*p_q[1:0] +: 8];
    assign out_byte = (cmd_q == `EEPC_OP_RDSR) ? sr_l2_q : rd_byte;
    assign rd_phase = fpor_q && ((cmd_q == `EEPC_OP_RDSR) ?
        byt_q != 3'h0 : (is_rd_l && byt_q == `EEPC_DATA_BYTE &&
        !sr_l2_q[`EEPC_SR_WIP]));

    // Corrected byte shifts out with no added edge [RQ10] [RQ17]
    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            so_q <= 1'b0;
            oe_q <= 1'b0; // [RQ6]
        end else begin
            so_q <= out_byte[3'(~bit_q)];
            oe_q <= rd_phase;
        end
    end

    assign spi_miso = so_q;
    assign spi_miso_oe = oe_q & ~spi_cs_n; // [RQ6]

    // ---- Core side, on aclk
    eepc_pkg::eepc_state_t st_q;
    logic [2:0] cs_s_q;
    logic [1:0] frm_s_q;
    logic seen_q, wel_q;
    logic [AW-1:0] grp_q;
    logic [1:0] wa_q;
    logic [7:0] wd_q;
    logic [TB-1:0] tmr_q;
    logic [CW-1:0] a_rdata, a_wdata;
    logic [31:0] mrg_d;
    logic [5:0] inj_pos_q;
    logic inj_en_q, write_in_progress_flag, cs_rise, new_f, acc, prot, id_ok;
    logic wren_go, wrdi_go, status_register_write_cmd_go, mem_go, lid_go, wr_hit;

    // Guard bits model non-volatile cells: delivered at 0, no reset
    logic swg_q = 1'b0; // [RQ12]
    logic bph_q = 1'b0; // [RQ12]
    logic bpl_q = 1'b0; // [RQ12]
    logic lock_q = 1'b0;

    assign write_in_progress_flag = st_q != eepc_pkg::ST_IDLE; // [RQ3]
    assign sr_byte = {swg_q, 3'h0, bph_q, bpl_q, wel_q, write_in_progress_flag};
    assign cs_rise = cs_s_q[1] & ~cs_s_q[2];
    assign new_f = frm_s_q[1] != seen_q;
    // Only whole frames started after reset, with no cycle running
    assign acc = cs_rise && new_f && fpor_q && endb_q &&
        st_q == eepc_pkg::ST_IDLE; // [RQ1] [RQ16]
    assign prot = bph_q ? (bpl_q || wad_q[AB-1]) :
        (bpl_q && wad_q[AB-1:AB-2] == 2'b11);
    assign id_ok = !(bph_q && bpl_q);
    assign wren_go = acc && cmd_q == `EEPC_OP_WREN && lastb_q == 3'h0;
    assign wrdi_go = acc && cmd_q == `EEPC_OP_WRDI && lastb_q == 3'h0;
    assign status_register_write_cmd_go = acc && wel_q && cmd_q == `EEPC_OP_STATUS_REGISTER_WRITE_CMD &&
        lastb_q == 3'h1; // [RQ14]
    assign mem_go = acc && wel_q && lastb_q == `EEPC_DATA_BYTE &&
        ((cmd_q == `EEPC_OP_WRITE && !prot) ||
        (cmd_q == `EEPC_OP_IDENT_PAGE_WRITE_CMD && !addr_q[`EEPC_ID_SEL_BIT] &&
        !lock_q && id_ok)); // [RQ14]
    assign lid_go = acc && wel_q && lastb_q == `EEPC_DATA_BYTE &&
        cmd_q == `EEPC_OP_IDENT_PAGE_WRITE_CMD && addr_q[`EEPC_ID_SEL_BIT] &&
        data_q[`EEPC_LOCK_BIT] && id_ok; // [RQ14]

    // Link record is quiet for two aclk edges once select is seen high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cs_s_q <= 3'b111; // [RQ5]
            // Frames that ended in reset count as seen, not as new
            frm_s_q <= {frm_s_q[0], frm_q};
            seen_q <= frm_s_q[1];
        end else begin
            cs_s_q <= {cs_s_q[1:0], spi_cs_n};
            frm_s_q <= {frm_s_q[0], frm_q};
            if (cs_rise) begin
                seen_q <= frm_s_q[1];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wel_q <= 1'b0; // [RQ2]
        end else if (wren_go) begin
            wel_q <= 1'b1;
        end else if (wrdi_go || status_register_write_cmd_go || mem_go || lid_go) begin
            wel_q <= 1'b0;
        end
    end

    // Stored bits change only by instruction, never by reset [RQ4]
    always_ff @(posedge aclk) begin
        if (status_register_write_cmd_go) begin
            swg_q <= data_q[`EEPC_SR_SWG];
            bph_q <= data_q[`EEPC_SR_BPH];
            bpl_q <= data_q[`EEPC_SR_BPL];
        end
        if (lid_go) begin
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= eepc_pkg::ST_IDLE; // [RQ3] [RQ5]
            tmr_q <= '0;
            grp_q <= '0;
            wa_q <= 2'h0;
            wd_q <= 8'h00;
        end else begin
            case (st_q)
                eepc_pkg::ST_IDLE: begin
                    tmr_q <= TB'(TW_CYC - 1);
                    if (mem_go) begin
                        st_q <= eepc_pkg::ST_FETCH; // [RQ15]
                        grp_q <= grp_of(cmd_q[7], wad_q); // [RQ8]
                        wa_q <= wad_q[1:0];
                        wd_q <= data_q;
                    end else if (status_register_write_cmd_go || lid_go) begin
                        st_q <= eepc_pkg::ST_CYC; // [RQ15]
                    end
                end
                eepc_pkg::ST_FETCH: st_q <= eepc_pkg::ST_MERGE;
                eepc_pkg::ST_MERGE: st_q <= eepc_pkg::ST_CYC; // [RQ9]
                eepc_pkg::ST_CYC: begin
                    if (tmr_q == '0) begin
                        st_q <= eepc_pkg::ST_IDLE;
                    end else begin
                        tmr_q <= tmr_q - TB'(1); // [RQ15]
                    end
                end
                default: st_q <= eepc_pkg::ST_IDLE;
            endcase
        end
    end

    // Whole group rewritten: old bytes repaired, check bits new [RQ9]
    always_comb begin
        mrg_d = ecc_dec(a_rdata);
        mrg_d[8*wa_q +: 8] = wd_q;
    end
    assign a_wdata = ecc_enc(mrg_d) ^
        (inj_en_q ? (CW'(1) << inj_pos_q) : CW'(0));

    eepc_mem #(
        .W(CW),
        .DEPTH(DEPTH),
        .FILL(FILL_CW), // [RQ11]
        .SP_IDX(GROUPS),
        .SP_VAL(ID_CW), // [RQ13]
        .AW(AW)
    ) u_mem (
        .a_clk(aclk),
        .a_we(st_q == eepc_pkg::ST_MERGE),
        .a_addr(grp_q),
        .a_wdata(a_wdata),
        .a_rdata(a_rdata),
        .b_clk(spi_sck),
        .b_addr(grp_of(cmd_q[7], p_d)),
        .b_rdata(b_rdata)
    );

    // ---- AXI4-Lite slave
    logic aw_v_q, w_v_q, bv_q, rv_q;
    logic [7:0] aw_a_q;
    logic [31:0] wd_a_q, rd_q;
    logic [3:0] ws_q;
    logic [1:0] bresp_q, rresp_q;

    assign s_axi_awready = !aw_v_q;
    assign s_axi_wready = !w_v_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rresp_q;
    assign wr_hit = aw_v_q && w_v_q && !bv_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_v_q <= 1'b0;
            w_v_q <= 1'b0;
            bv_q <= 1'b0;
            aw_a_q <= 8'h00;
            wd_a_q <= 32'h0;
            ws_q <= 4'h0;
            bresp_q <= `EEPC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_v_q) begin
                aw_v_q <= 1'b1;
                aw_a_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_v_q) begin
                w_v_q <= 1'b1;
                wd_a_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_hit) begin
                aw_v_q <= 1'b0;
                w_v_q <= 1'b0;
                bv_q <= 1'b1;
                bresp_q <= (aw_a_q == `EEPC_REG_STATUS ||
                    aw_a_q == `EEPC_REG_INJECT) ?
                    `EEPC_RESP_OKAY : `EEPC_RESP_SLVERR;
            end else if (bv_q && s_axi_bready) begin
                bv_q <= 1'b0;
            end
        end
    end

    // Fault injection arms one flipped bit for the next group write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inj_pos_q <= 6'h00;
            inj_en_q <= 1'b0;
        end else if (wr_hit && aw_a_q == `EEPC_REG_INJECT) begin
            if (ws_q[0]) begin
                inj_pos_q <= wd_a_q[5:0];
            end
            if (ws_q[1]) begin
                inj_en_q <= wd_a_q[`EEPC_INJ_EN_BIT];
            end
        end else if (st_q == eepc_pkg::ST_MERGE) begin
            inj_en_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rv_q <= 1'b0;
            rd_q <= 32'h0;
            rresp_q <= `EEPC_RESP_OKAY;
        end else if (s_axi_arvalid && !rv_q) begin
            rv_q <= 1'b1;
            rresp_q <= `EEPC_RESP_OKAY;
            case (s_axi_araddr)
                `EEPC_REG_STATUS: rd_q <= {22'h0, !write_in_progress_flag && cs_s_q[1],
                    lock_q, sr_byte}; // [RQ5]
                `EEPC_REG_INJECT: rd_q <= {23'h0, inj_en_q, 2'h0,
                    inj_pos_q};
                default: begin
                    rd_q <= 32'h0;
                    rresp_q <= `EEPC_RESP_SLVERR;
                end
            endcase
        end else if (rv_q && s_axi_rready) begin
            rv_q <= 1'b0;
        end
    end

    // ---- Checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_fetch;
        st_q == eepc_pkg::ST_FETCH ##1 st_q == eepc_pkg::ST_MERGE;
    endsequence
    sequence s_busy_frame;
        cs_rise && new_f && st_q == eepc_pkg::ST_CYC;
    endsequence

    a_por_wel: assert property ($rose(aresetn) |-> !wel_q) // [RQ2]
        else $error("write enable latch set after reset");
    a_por_wip: assert property ($rose(aresetn) |-> !write_in_progress_flag) // [RQ3]
        else $error("write in progress after reset");
    a_por_guard: assert property ($rose(aresetn) |->
        $stable({swg_q, bph_q, bpl_q})) // [RQ4]
        else $error("guard bits changed by reset");
    a_por_ignore: assert property (cs_rise && new_f && !fpor_q |=>
        !write_in_progress_flag && $stable({wel_q, swg_q, bph_q, bpl_q})) // [RQ1]
        else $error("frame from before reset was executed");
    a_sel_only: assert property (spi_cs_n |-> !oe_q) // [RQ6]
        else $error("serial output driven while deselected");
    a_ecc_fix: assert property (st_q == eepc_pkg::ST_MERGE |->
        ecc_dec(a_wdata) == mrg_d) // [RQ7]
        else $error("single bit error not corrected");
    a_grp_align: assert property (mem_go |=>
        grp_q == ($past(cmd_q[7]) ? AW'(GROUPS) + AW'($past(wad_q[7:2])) :
        AW'($past(wad_q) >> 2)))
        // [RQ8]
        else $error("group address not aligned");
    a_grp_rewrite: assert property (s_fetch |->
        $stable(grp_q) ##1 st_q == eepc_pkg::ST_CYC) // [RQ9]
        else $error("group not rewritten in place");
    a_cyc_start: assert property (status_register_write_cmd_go || lid_go || mem_go |=> write_in_progress_flag)
        // [RQ14]
        else $error("write instruction started no cycle");
    a_cyc_edge: assert property ($rose(write_in_progress_flag) |-> $past(cs_rise))
        // [RQ15]
        else $error("write cycle began away from select release");
    a_cyc_len: assert property ($rose(st_q == eepc_pkg::ST_CYC) |->
        (st_q == eepc_pkg::ST_CYC) [*8]) // [RQ15]
        else $error("write cycle ended early");
    a_busy_drop: assert property (s_busy_frame |=>
        $stable({swg_q, bph_q, bpl_q, lock_q}) && !$rose(wel_q)) // [RQ16]
        else $error("instruction executed during write cycle");
endmodule
`default_nettype wire

// file: src/eepc_defs.svh
// Constants of the serial EEPROM core: offsets, fields, codes, timing
`ifndef EEPC_DEFS_SVH
`define EEPC_DEFS_SVH
`define EEPC_CLK_NS 50
`define EEPC_TW_NS 5000000
`define EEPC_TW_CYC ((`EEPC_TW_NS) / (`EEPC_CLK_NS))
`define EEPC_GROUPS 65536
`define EEPC_ID_GROUPS 64
`define EEPC_ID_CODE 24'h5ac301
`define EEPC_CW_W 38
`define EEPC_CHK_W 6
`define EEPC_ERASED 8'hff
`define EEPC_OP_STATUS_REGISTER_WRITE_CMD 8'h01
`define EEPC_OP_WRITE 8'h02
`define EEPC_OP_READ 8'h03
`define EEPC_OP_WRDI 8'h04
`define EEPC_OP_RDSR 8'h05
`define EEPC_OP_WREN 8'h06
`define EEPC_OP_IDENT_PAGE_WRITE_CMD 8'h82
`define EEPC_OP_RDID 8'h83
`define EEPC_SR_WIP 0
`define EEPC_SR_WEL 1
`define EEPC_SR_BPL 2
`define EEPC_SR_BPH 3
`define EEPC_SR_SWG 7
`define EEPC_ID_SEL_BIT 10
`define EEPC_LOCK_BIT 1
`define EEPC_DATA_BYTE 3'h4
`define EEPC_REG_STATUS 8'h00
`define EEPC_REG_INJECT 8'h04
`define EEPC_INJ_EN_BIT 8
`define EEPC_ST_STANDBY_BIT 9
`define EEPC_ST_LOCK_BIT 8
`define EEPC_RESP_OKAY 2'h0
`define EEPC_RESP_SLVERR 2'h2
`endif

// file: src/eepc_mem.sv
// Dual-clock array of ECC code words with registered read ports
`timescale 1ns/1ps
`default_nettype none
module eepc_mem #(
    parameter int W = 38,
    parameter int DEPTH = 64,
    parameter logic [W-1:0] FILL = '1,
    parameter int SP_IDX = 0,
    parameter logic [W-1:0] SP_VAL = '1,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic a_clk,
    input wire logic a_we,
    input wire logic [AW-1:0] a_addr,
    input wire logic [W-1:0] a_wdata,
    output logic [W-1:0] a_rdata,
    input wire logic b_clk,
    input wire logic [AW-1:0] b_addr,
    output logic [W-1:0] b_rdata
);
    if (DEPTH > (1 << AW) || SP_IDX >= DEPTH) begin : g_bad
        $error("eepc_mem: depth does not fit address");
    end

    typedef logic [W-1:0] eepc_mem_t [DEPTH];

    // Delivered contents: erased words, one special word
    function automatic eepc_mem_t fill_mem();
        eepc_mem_t m;
        for (int i = 0; i < DEPTH; i++) begin
            m[i] = (i == SP_IDX) ? SP_VAL : FILL;
        end
        return m;
    endfunction

    // Initialiser, not a process: the write port stays the only driver
    eepc_mem_t mem_q = fill_mem();

    always_ff @(posedge a_clk) begin
        if (a_we) begin
            mem_q[a_addr] <= a_wdata;
        end
        a_rdata <= mem_q[a_addr];
    end

    // Port b reads on every rising serial clock edge; the core drops the read data while busy
    always_ff @(posedge b_clk) begin
        b_rdata <= mem_q[b_addr];
    end
endmodule
`default_nettype wire

// file: src/eepc_pkg.sv
// Types of the serial EEPROM core
package eepc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_MERGE = 4'b0100,
        ST_CYC = 4'b1000
    } eepc_state_t;
    typedef logic [37:0] eepc_cw_t;
endpackage

// file: verification/eepc_spi_master.sv
// SPI bus master model that selects the one core on the bus
`timescale 1ns/1ps
`default_nettype none
module eepc_spi_master (
    output logic sck,
    output logic cs_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    initial begin
        {sck, mosi} = 2'b00;
        cs_n = 1'b1;
    end
    // Clock runs only inside frames; a released data line reads as the
    // inverse of the last bit so stale values never pass
    task automatic frame(input logic [39:0] tx, input int nb,
                         output logic [7:0] rx);
        rx = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            mosi = tx[39 - i];
            #7.5 sck = 1'b1;
            rx = {rx[6:0], miso_oe ? miso : ~rx[0]};
            #7.5 sck = 1'b0;
        end
        #7.5 cs_n = 1'b1;
        mosi = ~mosi;
        // Deselect gap well above the core's minimum
        #400;
    endtask
endmodule
`default_nettype wire

// file: verification/test_eepc_core.sv
// Self-checking bench for the serial EEPROM core
`timescale 1ns/1ps
`default_nettype none
module test_eepc_core;
    localparam logic [23:0] ID = 24'h3c9a17; // Arbitrary value
    logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid;
    logic awready, wready, arready, rvalid, rready, sck, cs_n, mosi;
    logic miso, miso_oe;
    logic [7:0] awaddr, araddr, rx, a, d;
    logic [7:0] mem [256];
    logic [31:0] wdata, rdata, s;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int n_mismatch = 0, check_count = 0, cyc = 0, k;
    eepc_core #(.GROUPS(64), .TW_CYC(64), .ID_CODE(ID)) eepc_core_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .spi_sck(sck), .spi_cs_n(cs_n),
        .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe));
    eepc_spi_master eepc_spi_master_inst (.sck(sck), .cs_n(cs_n),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    function automatic logic [31:0] stat(input logic [1:0] bg);
        return {22'h0, 1'b1, 3'h0, 2'h0, bg, 2'h0};
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, x);
        check_count++;
        if (x !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, e, x);
        end
    endtask
    task automatic axw(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {ad, dt, 4'h3};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] ad);
        @(posedge aclk);
        araddr <= ad;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        {s, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    task automatic wcmd(input logic [39:0] tx, input int nb);
        eepc_spi_master_inst.frame(40'h06 << 32, 8, rx);
        eepc_spi_master_inst.frame(tx, nb, rx);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        foreach (mem[i]) mem[i] = 8'hff;
        void'($urandom(61940));
        // This frame starts in reset and ends after it: must be ignored
        fork
            #400 eepc_spi_master_inst.frame(40'h06 << 32, 8, rx);
        join_none
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        axr(8'h00);
        chk("status", stat(2'b00), s);
        chk("miso_oe", 32'h0, {31'h0, miso_oe});
        $display("test power-on done");
        for (int i = 0; i < 3; i++) begin
            eepc_spi_master_inst.frame({8'h83, 16'h0, i[7:0], 8'h0}, 40, rx);
            chk("ident", {24'h0, ID[23 - 8 * i -: 8]}, {24'h0, rx});
        end
        for (int j = 0; j < 6; j++) begin
            k = $urandom % 38;
            a = 8'($urandom);
            d = 8'($urandom);
            eepc_spi_master_inst.frame({8'h03, 16'h0, a, 8'h0}, 40, rx);
            chk("array", {24'h0, mem[a]}, {24'h0, rx});
            axw(8'h04, {23'h0, 1'b1, 2'h0, 6'(k)});
            wcmd({8'h02, 16'h0, a, d}, 40);
            // Second write lands inside the running cycle and must vanish
            wcmd({8'h02, 16'h0, a ^ 8'h01, ~d}, 40);
            axr(8'h00);
            chk("wip", 32'h1, {31'h0, s[0]});
            do axr(8'h00); while (s[0] !== 1'b0);
            mem[a] = d;
            for (int m = 0; m < 4; m++) begin
                eepc_spi_master_inst.frame({8'h03, 16'h0, a[7:2],
                    m[1:0], 8'h0}, 40, rx);
                chk("group", {24'h0, mem[{a[7:2], m[1:0]}]},
                    {24'h0, rx});
            end
        end
        $display("test ecc groups done");
        axr(8'h08);
        chk("unmapped rresp", 32'h2, {30'h0, r});
        chk("unmapped rdata", 32'h0, s);
        axw(8'h0c, 32'h0);
        chk("unmapped wr", 32'h2, {30'h0, r});
        $display("test register bus done");
        wcmd({8'h01, 8'h0c, 24'h0}, 16);
        do axr(8'h00); while (s[0] !== 1'b0);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(8'h00);
        chk("status", stat(2'b11), s);
        eepc_spi_master_inst.frame(40'h05 << 32, 16, rx);
        chk("rdsr", 32'h0c, {24'h0, rx});
        $display("test second reset done");
        test_done();
    end
endmodule
`default_nettype wire
